// File: rtl/config_word_prog_mode_wake.sv
// Behaviour
// - Config word at 2007h, programmed reads zero
// - Config space reachable only in programming; the side port reads the config word at any time
// - Program protect fields active low
// - Data protect bit active low
// - Enabled flagged source wakes, ignoring global
// - Pending before sleep: sleep is nop
// - Interrupt during sleep: complete, then wake
// - Program memory readout only while unprotected
// - Four ID locations, program mode only
// - ID locations keep low four bits
// - Port pins become programming clock, data
// - Entry sets program counter to zero
// - Six-bit command then fourteen data bits
// - Mask-ROM: program writes refused, data allowed
//
// Local design decisions: the strobed register port and the placing of the registers.
`timescale 1ns/1ps
`include "cfg_prog_defines.svh"
module config_word_prog_mode_wake
  import cfg_prog_pkg::*;
#(
  parameter bit ROM_VARIANT = 1'b0
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic programming_high_voltage,
  input wire logic prog_clock_pin,
  input wire logic prog_data_pin_in,
  output logic prog_data_pin_out,
  output logic prog_data_pin_oe,
  output logic progMode,
  output logic [13:0] progCounter,
  output logic memWrStb,
  output logic memWrData,
  output mem_req_t memReq,
  input wire logic [13:0] memRdData,
  input wire logic [3:0] irqEnable,
  input wire logic [3:0] irqFlag,
  input wire logic global_irq_enable,
  input wire logic sleepExec,
  input wire logic clear_watchdog_instr,
  output logic wdtClear,
  output logic timeout_flag_n,
  output logic powerdown_flag_n,
  output logic sleeping,
  output cfg_decode_t cfgDecode,
  input wire logic [3:0] regAddr,
  input wire logic [13:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [13:0] regRdData,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchronisers
  logic [1:0] hvSync, clkSync, datSync;
  logic clkPrev;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hvSync <= 2'h0;
      clkSync <= 2'h0;
      datSync <= 2'h0;
      clkPrev <= 1'b0;
    end else begin
      hvSync <= {hvSync[0], programming_high_voltage};
      clkSync <= {clkSync[0], prog_clock_pin};
      datSync <= {datSync[0], prog_data_pin_in};
      clkPrev <= clkSync[1];
    end
  end
  logic clkRise, clkFall;
  assign clkRise = clkSync[1] & ~clkPrev;
  assign clkFall = ~clkSync[1] & clkPrev;

  // Address class decoding used by readout and write paths
  function automatic logic inCfgSpace(input logic [13:0] a);
    inCfgSpace = (a >= `CFG_SPACE_LO) && (a <= `CFG_SPACE_HI);
  endfunction : inCfgSpace
  function automatic logic isIdLoc(input logic [13:0] a);
    isIdLoc = (a >= `ID_LOC_LO) && (a <= `ID_LOC_HI);
  endfunction : isIdLoc

  ////////////////////////////////////////////////////////////////////////
  // Configuration storage
  logic [13:0] cfgWord_reg;
  logic [3:0] idLoc_reg [0:3];
  logic [13:0] addr_reg;
  logic [5:0] cmd_reg;
  logic [15:0] shift_reg;
  logic [4:0] bitCnt_reg;
  logic [13:0] rdWord_reg;
  logic ppProt;
  // Any programmed protect bit protects the whole array
  assign ppProt = ~(&{cfgWord_reg[`CFG_PP_HI_MSB:`CFG_PP_HI_LSB],
    cfgWord_reg[`CFG_PP_LO_MSB:`CFG_PP_LO_LSB]});

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CMD,
    ST_DATA
  } link_state_t;
  link_state_t state_reg;

  ////////////////////////////////////////////////////////////////////////
  // Mode entry: clock and data low while high voltage rises
  logic hvPrev;
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      hvPrev <= 1'b0;
      progMode <= 1'b0;
    end else begin
      hvPrev <= hvSync[1];
      if (!hvSync[1]) begin
        progMode <= 1'b0;
      end else if (!hvPrev && !clkSync[1] && !datSync[1]) begin
        progMode <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Serial command and data engine, sampled on clock falling edge
  logic cmdIsLoad, cmdIsRead, writeOk;
  assign cmdIsLoad = (cmd_reg == `CMD_LOAD_CFG) ||
    (cmd_reg == `CMD_LOAD_PROG) || (cmd_reg == `CMD_LOAD_DATA);
  assign cmdIsRead = (cmd_reg == `CMD_READ_PROG) ||
    (cmd_reg == `CMD_READ_DATA);
  // ROM parts keep program memory fixed
  assign writeOk = !(ROM_VARIANT && cmd_reg == `CMD_LOAD_PROG);

  logic [5:0] cmdNext;
  assign cmdNext = {datSync[1], shift_reg[15:11]};

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= ST_IDLE;
      cmd_reg <= 6'h00;
      shift_reg <= 16'h0000;
      bitCnt_reg <= 5'h00;
      addr_reg <= `PC_ENTRY;
    end else if (!progMode) begin
      state_reg <= ST_IDLE;
      bitCnt_reg <= 5'h00;
      addr_reg <= `PC_ENTRY;
    end else begin
      unique case (state_reg)
        ST_IDLE: begin
          state_reg <= ST_CMD;
          bitCnt_reg <= 5'h00;
        end
        ST_CMD: if (clkFall) begin
          shift_reg <= {datSync[1], shift_reg[15:1]};
          if (bitCnt_reg == `CMD_BITS - 5'h01) begin
            cmd_reg <= cmdNext;
            bitCnt_reg <= 5'h00;
            if (cmdNext == `CMD_INC_ADDR) begin
              addr_reg <= addr_reg + 14'h0001;
            end else if (cmdNext != `CMD_BEGIN_PROG) begin
              state_reg <= ST_DATA;
            end
            if (cmdNext == `CMD_LOAD_CFG) begin
              addr_reg <= `CFG_SPACE_LO;
            end
          end else begin
            bitCnt_reg <= bitCnt_reg + 5'h01;
          end
        end
        ST_DATA: if (clkFall) begin
          shift_reg <= {datSync[1], shift_reg[15:1]};
          if (bitCnt_reg == `DATA_BITS - 5'h01) begin
            bitCnt_reg <= 5'h00;
            state_reg <= ST_CMD;
          end else begin
            bitCnt_reg <= bitCnt_reg + 5'h01;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // End of a load frame: start and stop bits frame 14 data bits
  logic loadDone;
  assign loadDone = progMode && state_reg == ST_DATA && clkFall &&
    bitCnt_reg == `DATA_BITS - 5'h01 && cmdIsLoad;
  logic [13:0] loadData;
  assign loadData = shift_reg[15:2];

  ////////////////////////////////////////////////////////////////////////
  // Config word and ID writes, only reachable in program mode
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfgWord_reg <= `CFG_WORD_RESET;
    end else if (loadDone && addr_reg == `CFG_WORD_ADDR) begin
      cfgWord_reg <= loadData;
    end
  end

  generate
    for (genvar i = 0; i < 4; i++) begin : g_id
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          idLoc_reg[i] <= 4'hF;
        end else if (loadDone && addr_reg == `ID_LOC_LO + 14'(i)) begin
          idLoc_reg[i] <= loadData[`ID_WIDTH-1:0];
        end
      end
    end
  endgenerate

  // Memory write strobe toward the array outside
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      memWrStb <= 1'b0;
      memWrData <= 1'b0;
      memReq <= '0;
    end else begin
      memWrStb <= loadDone && writeOk && !inCfgSpace(addr_reg);
      memWrData <= loadDone && cmd_reg == `CMD_LOAD_DATA;
      memReq <= '{addr: addr_reg, data: loadData};
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Readout: protected array reads as zero
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rdWord_reg <= 14'h0000;
    end else if (state_reg == ST_CMD && clkFall &&
                 bitCnt_reg == `CMD_BITS - 5'h01) begin
      if (addr_reg == `CFG_WORD_ADDR) begin
        rdWord_reg <= cfgWord_reg;
      end else if (isIdLoc(addr_reg)) begin
        rdWord_reg <= {10'h000, idLoc_reg[addr_reg[1:0]]};
      end else if (inCfgSpace(addr_reg)) begin
        rdWord_reg <= 14'h3FFF;
      end else if (ppProt && cmdNext == `CMD_READ_PROG) begin
        rdWord_reg <= 14'h0000;
      end else begin
        rdWord_reg <= memRdData;
      end
    end
  end

  // Data pin drive: bit changes on rising clock during read frame
  logic [3:0] rdIdx;
  assign rdIdx = 4'(bitCnt_reg - 5'h01);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prog_data_pin_out <= 1'b0;
      prog_data_pin_oe <= 1'b0;
    end else if (progMode && state_reg == ST_DATA && cmdIsRead) begin
      if (clkRise) begin
        prog_data_pin_oe <= 1'b1;
        prog_data_pin_out <= (bitCnt_reg == 5'h00 ||
          bitCnt_reg == `DATA_BITS - 5'h01) ? 1'b0 : rdWord_reg[rdIdx];
      end
    end else begin
      prog_data_pin_oe <= 1'b0;
      prog_data_pin_out <= 1'b0;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      progCounter <= `PC_ENTRY;
    end else begin
      progCounter <= addr_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Config decode, applied from reset onward
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      cfgDecode <= '{1'b0, 1'b0, 1'b0, 1'b1, OSC_RC};
    end else begin
      cfgDecode.programProtect <= ppProt;
      cfgDecode.dataProtect <= ~cfgWord_reg[`CFG_DP_BIT];
      cfgDecode.powerupTimerEnable <= ~cfgWord_reg[`CFG_PWRT_BIT];
      cfgDecode.watchdogEnable <= cfgWord_reg[`CFG_WDT_BIT];
      cfgDecode.oscMode <=
        osc_mode_t'(cfgWord_reg[`CFG_OSC_MSB:`CFG_OSC_LSB]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Sleep and wake: global enable is deliberately ignored here
  logic wakeReq;
  assign wakeReq = |(irqEnable & irqFlag);
  logic sleepCmd;
  assign sleepCmd = sleepExec || (regWr && regAddr == `REG_SLEEP);
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      timeout_flag_n <= 1'b1;
      powerdown_flag_n <= 1'b1;
      sleeping <= 1'b0;
      wdtClear <= 1'b0;
    end else begin
      wdtClear <= 1'b0;
      if (sleepCmd && !wakeReq && !sleeping) begin
        sleeping <= 1'b1;
        wdtClear <= 1'b1;
        timeout_flag_n <= 1'b1;
        powerdown_flag_n <= 1'b0;
      end else if (sleepCmd && wakeReq) begin
        sleeping <= 1'b0;
      end else if (sleeping && wakeReq) begin
        sleeping <= 1'b0;
      end else if (clear_watchdog_instr) begin
        wdtClear <= 1'b1;
        timeout_flag_n <= 1'b1;
        powerdown_flag_n <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Events, mask and interrupt
  logic [3:0] status_reg, mask_reg, events;
  assign events = {sleeping && wakeReq, loadDone && !writeOk,
    loadDone && writeOk, hvSync[1] && !hvPrev};
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_reg <= 4'h0;
    end else begin
      // Set beats clear in the same cycle
      status_reg <= (status_reg & ~((regWr && regAddr == `REG_STATUS) ?
        regWrData[3:0] : 4'h0)) | events;
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mask_reg <= 4'h0;
    end else if (regWr && regAddr == `REG_MASK) begin
      mask_reg <= regWrData[3:0];
    end
  end
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(status_reg & mask_reg);
    end
  end

  // Register read port, data one cycle after strobe
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      regRdData <= 14'h0000;
    end else if (regRd) begin
      unique case (regAddr)
        `REG_STATUS: regRdData <= {10'h000, status_reg};
        `REG_MASK: regRdData <= {10'h000, mask_reg};
        `REG_CONFIG: regRdData <= cfgWord_reg;
        `REG_SLEEP: regRdData <= {11'h000, sleeping, timeout_flag_n,
          powerdown_flag_n};
        `REG_ADDR: regRdData <= addr_reg;
        default: regRdData <= 14'h0000;
      endcase
    end else begin
      regRdData <= 14'h0000;
    end
  end

endmodule : config_word_prog_mode_wake

// File: rtl/cfg_prog_defines.svh
`ifndef CFG_PROG_DEFINES_SVH
`define CFG_PROG_DEFINES_SVH
// Configuration space addresses
`define CFG_WORD_ADDR 14'h2007
`define CFG_SPACE_LO 14'h2000
`define CFG_SPACE_HI 14'h3FFF
`define ID_LOC_LO 14'h2000
`define ID_LOC_HI 14'h2003
`define PC_ENTRY 14'h0000
// Configuration word fields
`define CFG_PP_HI_MSB 13
`define CFG_PP_HI_LSB 8
`define CFG_DP_BIT 7
`define CFG_PP_LO_MSB 6
`define CFG_PP_LO_LSB 4
`define CFG_PWRT_BIT 3
`define CFG_WDT_BIT 2
`define CFG_OSC_MSB 1
`define CFG_OSC_LSB 0
`define CFG_WORD_RESET 14'h3FFF
`define ID_WIDTH 4
// Serial framing
`define CMD_BITS 5'h06
`define DATA_BITS 5'h10
// Commands
`define CMD_LOAD_CFG 6'h00
`define CMD_LOAD_PROG 6'h02
`define CMD_READ_PROG 6'h04
`define CMD_INC_ADDR 6'h06
`define CMD_BEGIN_PROG 6'h08
`define CMD_LOAD_DATA 6'h03
`define CMD_READ_DATA 6'h05
// Register map of the side port
`define REG_STATUS 4'h0
`define REG_MASK 4'h1
`define REG_CONFIG 4'h2
`define REG_SLEEP 4'h3
`define REG_ADDR 4'h4
// Sticky event bits
`define EV_ENTER 0
`define EV_WRITE 1
`define EV_REFUSED 2
`define EV_WAKE 3
`define EV_COUNT 4
`endif

// File: rtl/cfg_prog_pkg.sv
package cfg_prog_pkg;
  typedef enum logic [1:0] {
    OSC_LP,
    OSC_XT,
    OSC_HS,
    OSC_RC
  } osc_mode_t;
  typedef struct packed {
    logic programProtect;
    logic dataProtect;
    logic powerupTimerEnable;
    logic watchdogEnable;
    osc_mode_t oscMode;
  } cfg_decode_t;
  typedef struct packed {
    logic [13:0] addr;
    logic [13:0] data;
  } mem_req_t;
endpackage : cfg_prog_pkg

// File: bench/config_word_prog_mode_wake_properties.sv
`timescale 1ns/1ps
module config_word_prog_mode_wake_properties (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic programming_high_voltage,
  input wire logic prog_data_pin_oe,
  input wire logic progMode,
  input wire logic [13:0] progCounter,
  input wire logic memWrStb,
  input wire logic [3:0] irqEnable,
  input wire logic [3:0] irqFlag,
  input wire logic sleepExec,
  input wire logic clear_watchdog_instr,
  input wire logic wdtClear,
  input wire logic timeout_flag_n,
  input wire logic powerdown_flag_n,
  input wire logic sleeping
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // Wake request ignores the global enable
  wire logic pending = |(irqEnable & irqFlag);
  // Real sleep: watchdog cleared, flags show it that cycle or up to two later
  sequence sSleepDone;
    ##[1:3] wdtClear ##[0:2] (!powerdown_flag_n && timeout_flag_n);
  endsequence
  // No-op sleep leaves watchdog and power-down flag alone
  sequence sNop;
    (!sleeping && !wdtClear && $stable(powerdown_flag_n)) [*3];
  endsequence
  AST_WR_IN_PROG: assert property (memWrStb |-> progMode)
    else $error("write outside program mode");
  AST_OE_IN_PROG: assert property (prog_data_pin_oe |-> progMode)
    else $error("data pin driven outside program mode");
  AST_ENTRY_HV: assert property (
    $rose(progMode) |-> programming_high_voltage)
    else $error("program mode without high voltage");
  AST_ENTRY_PC: assert property (
    $rose(progMode) |-> ##[0:1] progCounter == 14'h0000)
    else $error("counter not zero at entry");
  AST_EXIT: assert property (
    $fell(programming_high_voltage) |-> ##[1:6] !progMode)
    else $error("program mode kept");
  AST_SLEEP_NOP: assert property (sleepExec && pending |=> sNop)
    else $error("sleep not a no-op");
  AST_SLEEP_DONE: assert property (
    sleepExec && !pending |-> sSleepDone)
    else $error("sleep not completed");
  AST_WAKE: assert property (sleeping && pending |-> ##[1:4] !sleeping)
    else $error("no wake");
  AST_WDT_CLEAR: assert property (
    clear_watchdog_instr |-> ##[1:2] wdtClear)
    else $error("watchdog clear missing");
endmodule : config_word_prog_mode_wake_properties

// File: bench/prog_partner.sv
`timescale 1ns/1ps
`include "cfg_prog_defines.svh"
module prog_partner (
  output logic hv,
  output logic sclk,
  output logic dOut,
  output logic dOe,
  input wire logic dIn
);
  ////////////////////////////////////////
  // Idle: voltage off, clock stands low
  initial begin
    hv = 1'b0;
    sclk = 1'b0;
    dOut = 1'b0;
    dOe = 1'b1;
  end
  task automatic enter();
    sclk = 1'b0;
    dOut = 1'b0;
    dOe = 1'b1;
    #1010 hv = 1'b1;
    #2000;
  endtask : enter
  task automatic leave();
    #1000 hv = 1'b0;
    #2000;
  endtask : leave
  // Sampled late in the period so slow read data has settled
  task automatic bitClk(input logic b, input logic drv, output logic s);
    sclk = 1'b1;
    dOe = drv;
    dOut = b;
    #160;
    sclk = 1'b0;
    #160;
    s = dIn;
  endtask : bitClk
  // Command LSB first, then a 16-clock frame for loads and reads
  task automatic xfer(input logic [5:0] cmd, input logic [13:0] wd,
    output logic [13:0] rv);
    logic s;
    logic [15:0] f;
    bit rd;
    rd = cmd inside {`CMD_READ_PROG, `CMD_READ_DATA};
    f = {1'b0, wd, 1'b0};
    for (int i = 0; i < 6; i++) bitClk(cmd[i], 1'b1, s);
    #1000;
    if (rd || cmd inside {`CMD_LOAD_CFG, `CMD_LOAD_PROG, `CMD_LOAD_DATA}) begin
      for (int i = 0; i < 16; i++) begin
        bitClk(f[i], !rd, s);
        f[i] = s;
      end
      #1000;
    end
    dOe = 1'b1;
    rv = f[14:1];
  endtask : xfer
endmodule : prog_partner

// File: bench/config_word_prog_mode_wake_tb.sv
`timescale 1ns/1ps
`include "cfg_prog_defines.svh"
`define CHK(n, e, a) begin numChecks++; if ((a) !== (e)) begin fails++; \
  $display("MISMATCH %s exp %0h got %0h", n, e, a); end end
module config_word_prog_mode_wake_tb
  import cfg_prog_pkg::*;
;
  logic clk, sys_rst, programming_high_voltage, prog_clock_pin, progOut;
  logic progOe, prog_data_pin_in, prog_data_pin_out, prog_data_pin_oe;
  logic progMode, memWrStb, memWrData, global_irq_enable, sleepExec;
  logic clear_watchdog_instr, wdtClear, timeout_flag_n, powerdown_flag_n;
  logic sleeping, regWr, regRd, irq;
  logic floatLvl = 1'b0;
  logic rdPend = 1'b0;
  logic [13:0] progCounter, memRdData, regWrData, regRdData, memSeed, rdExp;
  logic [3:0] irqEnable, irqFlag, regAddr;
  mem_req_t memReq, wrExp;
  cfg_decode_t cfgDecode;
  logic [13:0] rdQ[$];
  mem_req_t wrQ[$];
  logic wdExp;
  logic wdQ[$];
  int fails = 0;
  int numChecks = 0;
  int seed;
  config_word_prog_mode_wake i_dut (.clk, .sys_rst, .programming_high_voltage,
    .prog_clock_pin, .prog_data_pin_in, .prog_data_pin_out, .prog_data_pin_oe,
    .progMode, .progCounter, .memWrStb, .memWrData, .memReq, .memRdData,
    .irqEnable, .irqFlag, .global_irq_enable, .sleepExec,
    .clear_watchdog_instr, .wdtClear, .timeout_flag_n, .powerdown_flag_n,
    .sleeping, .cfgDecode, .regAddr, .regWrData, .regWr, .regRd, .regRdData,
    .irq);
  prog_partner i_prog (.hv(programming_high_voltage), .sclk(prog_clock_pin),
    .dOut(progOut), .dOe(progOe), .dIn(prog_data_pin_in));
  ////////////////////////////////////////
  // Released line shows a changing pattern, never the last bit
  assign prog_data_pin_in = prog_data_pin_oe ? prog_data_pin_out
    : (progOe ? progOut : floatLvl);
  assign memRdData = progCounter ^ memSeed;
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Results are matched against the oldest note as they appear
  always @(posedge clk) begin
    if (rdPend) begin
      rdExp = rdQ.pop_front();
      `CHK("regRdData", rdExp, regRdData)
    end
    if (memWrStb) begin
      wrExp = 'x;
      if (wrQ.size() > 0) wrExp = wrQ.pop_front();
      `CHK("memReq", wrExp, memReq)
      wdExp = 1'bx;
      if (wdQ.size() > 0) wdExp = wdQ.pop_front();
      `CHK("memWrData", wdExp, memWrData)
    end
    rdPend <= regRd;
    floatLvl <= ~floatLvl;
  end
  function automatic cfg_decode_t dec(input logic [13:0] w);
    dec = {~&{w[13:8], w[6:4]}, ~w[7], ~w[3], w[2], w[1:0]};
  endfunction : dec
  task automatic wr(input logic [3:0] a, input logic [13:0] d);
    @(posedge clk);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, input logic [13:0] e);
    rdQ.push_back(e);
    @(posedge clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
  endtask : rd
  task automatic conclude();
    if (fails == 0 && numChecks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude
  // Cut a hang short
  initial begin
    #2000000;
    fails++;
    conclude();
  end
  initial begin
    logic [13:0] rv, dat, cfg;
    seed = 32'hB47411CE;
    sys_rst = 1'b1;
    {regWr, regRd, sleepExec, clear_watchdog_instr, global_irq_enable} = '0;
    {regAddr, regWrData, irqEnable, irqFlag, memSeed} = '0;
    repeat (10) @(posedge clk);
    sys_rst <= 1'b0;
    // Each pass programs one oscillator code; the last also protects
    for (int k = 0; k < 4; k++) begin
      if (k > 0) begin
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
      end
      repeat (2) @(posedge clk);
      `CHK("cfgReset", dec(14'h3FFF), cfgDecode)
      rd(4'h2, 14'h3FFF);
      dat = 14'($random(seed));
      memSeed <= 14'($random(seed));
      wrQ.push_back({14'h0000, dat});
      wdQ.push_back(1'b0);
      i_prog.enter();
      i_prog.xfer(`CMD_LOAD_PROG, dat, rv);
      i_prog.xfer(`CMD_READ_PROG, 14'h0000, rv);
      `CHK("readout", memSeed, rv)
      // Data EEPROM write one address up, then a data read of that address
      wrQ.push_back({14'h0001, ~dat});
      wdQ.push_back(1'b1);
      i_prog.xfer(`CMD_INC_ADDR, 14'h0000, rv);
      i_prog.xfer(`CMD_LOAD_DATA, ~dat, rv);
      i_prog.xfer(`CMD_BEGIN_PROG, 14'h0000, rv);
      i_prog.xfer(`CMD_READ_DATA, 14'h0000, rv);
      `CHK("dataRead", memSeed ^ 14'h0001, rv)
      i_prog.xfer(`CMD_LOAD_CFG, 14'h3FF0 | 14'(k), rv);
      i_prog.xfer(`CMD_READ_PROG, 14'h0000, rv);
      `CHK("idLocation", 4'(k), rv[3:0])
      repeat (7) i_prog.xfer(`CMD_INC_ADDR, 14'h0000, rv);
      i_prog.xfer(`CMD_READ_PROG, 14'h0000, rv);
      `CHK("cfgWord", 14'h3FFF, rv)
      cfg = (k == 3) ? 14'h0003 : (14'h3FFC | 14'(k));
      i_prog.xfer(`CMD_LOAD_PROG, cfg, rv);
      `CHK("cfgDecode", dec(cfg), cfgDecode)
      i_prog.leave();
      rd(4'h2, cfg);
      i_prog.enter();
      i_prog.xfer(`CMD_READ_PROG, 14'h0000, rv);
      `CHK("protRead", (k == 3) ? 14'h0000 : memSeed, rv)
      i_prog.leave();
    end
    // Entry and accepted writes seen, nothing refused
    rd(4'h0, 14'h0003);
    // Sleep with a wake request already pending
    wr(4'h0, 14'h000F);
    wr(4'h1, 14'h0008);
    rd(4'h0, 14'h0000);
    irqEnable <= 4'h2;
    irqFlag <= 4'h2;
    global_irq_enable <= 1'b1;
    @(posedge clk);
    sleepExec <= 1'b1;
    @(posedge clk);
    sleepExec <= 1'b0;
    repeat (4) @(posedge clk);
    rd(4'h3, 14'h0003);
    irqFlag <= 4'h0;
    global_irq_enable <= 1'b0;
    clear_watchdog_instr <= 1'b1;
    @(posedge clk);
    clear_watchdog_instr <= 1'b0;
    sleepExec <= 1'b1;
    @(posedge clk);
    sleepExec <= 1'b0;
    repeat (6) @(posedge clk);
    rd(4'h3, 14'h0006);
    `CHK("irqIdle", 1'b0, irq)
    // Wake with the global enable low
    irqEnable <= 4'h4;
    irqFlag <= 4'h4;
    repeat (6) @(posedge clk);
    `CHK("sleeping", 1'b0, sleeping)
    `CHK("irqWake", 1'b1, irq)
    rd(4'h3, 14'h0002);
    wr(4'h1, 14'h0000);
    repeat (2) @(posedge clk);
    `CHK("irqMasked", 1'b0, irq)
    wr(4'h1, 14'h0008);
    wr(4'h0, 14'h0008);
    rd(4'h0, 14'h0000);
    `CHK("irqCleared", 1'b0, irq)
    wr(4'h2, 14'h0000);
    rd(4'h2, 14'h0003);
    rd(4'hF, 14'h0000);
    // Let the last read answer be compared before the verdict
    repeat (2) @(posedge clk);
    `CHK("queues", 0, rdQ.size() + wrQ.size() + wdQ.size())
    conclude();
  end
endmodule : config_word_prog_mode_wake_tb
bind config_word_prog_mode_wake
  config_word_prog_mode_wake_properties i_props (.clk, .sys_rst,
  .programming_high_voltage, .prog_data_pin_oe, .progMode, .progCounter,
  .memWrStb, .irqEnable, .irqFlag, .sleepExec, .clear_watchdog_instr,
  .wdtClear, .timeout_flag_n, .powerdown_flag_n, .sleeping);
